/* File: logic/defl_port_map.vh */
// Constants for the deflection controller serial update port
`ifndef DEFL_PORT_MAP_VH
`define DEFL_PORT_MAP_VH

// Bus addressing
`define DEV_BUS_ADDRESS   8'h8c
`define SUB_MODE_BIT      7
`define BYTE_BITS         4'h8

// Register indices (low seven subaddress bits)
`define IDX_LIN_CTRL      7'h02
`define IDX_OVERSCAN      7'h0f
`define IDX_POWER         7'h1a
`define IDX_AMPLITUDE     7'h20
`define IDX_GAIN          7'h21
`define IDX_POSITION      7'h22
`define IDX_S_CORR        7'h23
`define IDX_S_BALANCE     7'h24
`define IDX_PARALLELOGRAM 7'h25
`define IDX_PIN_UNBAL     7'h26

// Field positions
`define BIT_LIN_FORCE     6
`define BIT_OVERSCAN      6
`define BIT_SOFT_START    1

// Neutral and full-scale codes
`define CODE_FULL_AMP     8'h7f
`define CODE_FULL_GAIN    8'h3f
`define CODE_POS_CENTRE   8'h40
`define CODE_BAL_NEUTRAL  8'h08
`define CODE_PAR_NEUTRAL  8'h20
`define CODE_PIN_NEUTRAL  8'h20
`define CODE_ZERO         8'h00

// Counter steps and cleared values
`define BIT_CNT_CLR       4'h0
`define BIT_CNT_STEP      4'h1
`define BYTE_CLR          8'h00
`define IDX_CLR           7'h00

`endif

/* File: logic/pin_sync.v */
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
	parameter W = 5
) (
	// Clock and reset
	input  wire         ref_clk,
	input  wire         reset,
	// Asynchronous levels in, synchronised levels out
	input  wire [W-1:0] async_in,
	output reg  [W-1:0] sync_out
);

	reg [W-1:0] meta_r;

	always @(posedge ref_clk) begin
		if (reset) begin
			meta_r   <= {W{1'b0}};
			sync_out <= {W{1'b0}};
		end else begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule // pin_sync

`default_nettype wire

/* File: logic/defl_reg_bank.v */
// Register array of the deflection controller with derived adjustment values
`timescale 1ns/10ps
`default_nettype none
`include "defl_port_map.vh"

module defl_reg_bank (
	// Clock
	input  wire       ref_clk,
	// Buffered transfer port
	input  wire       buf_we,
	input  wire [6:0] buf_index,
	input  wire [7:0] buf_data,
	// Direct write port, wins on a clash
	input  wire       dir_we,
	input  wire [6:0] dir_index,
	input  wire [7:0] dir_data,
	// Read port for the DAC section
	input  wire [6:0] rd_index,
	output reg  [7:0] rd_data,
	// Derived adjustments
	output reg        full_amplitude,
	output reg  [7:0] position_offset,
	output reg  [7:0] s_correction_eff,
	output reg  [7:0] balance_offset,
	output reg  [7:0] parallelogram_offset,
	output reg  [7:0] pin_unbalance_offset,
	output reg        soft_start_release
);

	reg [7:0] regs_r [0:127];

	function [7:0] from_neutral;
		input [7:0] code;
		input [7:0] neutral;
		begin
			from_neutral = code - neutral;
		end
	endfunction

	// No reset: contents are random until the host loads them
	always @(posedge ref_clk) begin
		if (buf_we)
			regs_r[buf_index] <= buf_data; // All eight bits in one edge
		if (dir_we)
			regs_r[dir_index] <= dir_data;
	end

	always @(posedge ref_clk) begin
		rd_data              <= regs_r[rd_index];
		full_amplitude       <= (regs_r[`IDX_AMPLITUDE] == `CODE_FULL_AMP) &&
		                        (regs_r[`IDX_GAIN] == `CODE_FULL_GAIN) &&
		                        !regs_r[`IDX_OVERSCAN][`BIT_OVERSCAN];
		position_offset      <= from_neutral(regs_r[`IDX_POSITION], `CODE_POS_CENTRE);
		balance_offset       <= from_neutral(regs_r[`IDX_S_BALANCE], `CODE_BAL_NEUTRAL);
		parallelogram_offset <= from_neutral(regs_r[`IDX_PARALLELOGRAM], `CODE_PAR_NEUTRAL);
		pin_unbalance_offset <= from_neutral(regs_r[`IDX_PIN_UNBAL], `CODE_PIN_NEUTRAL);
		if (regs_r[`IDX_LIN_CTRL][`BIT_LIN_FORCE])
			s_correction_eff <= `CODE_ZERO;
		else
			s_correction_eff <= regs_r[`IDX_S_CORR];
		soft_start_release   <= regs_r[`IDX_POWER][`BIT_SOFT_START];
	end

endmodule // defl_reg_bank

`default_nettype wire

/* File: logic/deflection_ctrl_i2c_update_port.v */
// Two-wire write port with direct and frame-synchronised register updates
`timescale 1ns/10ps
`default_nettype none
`include "defl_port_map.vh"

// Summary of operation
// - Respond only to bus address 8c
// - Start, address, subaddress, data, stop; acknowledges
// - No acknowledge while supply is low
// - Extra direct data bytes hit same register
// - Accept bus clock up to 400 kHz
// - Subaddress top bit 0 selects direct
// - Direct write applied at end of transmission
// - Subaddress top bit 1 selects buffered
// - Buffered byte held, applied at blanking
// - Buffered write acknowledges all three bytes
// - After buffered write, refuse until blanking
// - Standby disables buffered update mode
// - Full amplitude 127/63, position centre 64
// - Neutral codes: balance 8, parallelogram and pin unbalance 32
// - Centring bit forces zero linearity correction
module deflection_ctrl_i2c_update_port (
	// Clock and reset
	input  wire       ref_clk,
	input  wire       reset,
	// Serial bus pins
	input  wire       scl_in,
	input  wire       sda_in,
	output wire       sda_out,
	output reg        sda_oe,
	// Device state
	input  wire       vertical_blank_pulse,
	input  wire       standby_state,
	input  wire       supply_ok,
	// Status
	output reg        buffer_locked,
	// DAC section read port and derived values
	input  wire [6:0] rd_index,
	output wire [7:0] rd_data,
	output wire       full_amplitude,
	output wire [7:0] position_offset,
	output wire [7:0] s_correction_eff,
	output wire [7:0] balance_offset,
	output wire [7:0] parallelogram_offset,
	output wire [7:0] pin_unbalance_offset,
	output wire       soft_start_release
);

	wire [4:0] sync_w;
	wire       scl_s;
	wire       sda_s;
	wire       vbl_s;
	wire       stby_s;
	wire       pwr_s;
	reg        scl_d_r;
	reg        sda_d_r;
	reg        vbl_d_r;
	reg  [2:0] state_r;
	reg  [3:0] bit_cnt_r;
	reg  [7:0] shift_r;
	reg        ack_phase_r;
	reg  [7:0] sub_r;
	reg        buf_mode_r;
	reg  [7:0] dir_data_r;
	reg        dir_pend_r;
	reg  [7:0] hold_r;
	reg  [6:0] hold_idx_r;
	reg        armed_r;
	reg        dir_we;
	reg        buf_we;
	wire       scl_rise;
	wire       scl_fall;
	wire       start_cond;
	wire       stop_cond;
	wire       vbl_rise;
	wire       may_ack;
	wire       frame_end;
	wire       receiving;
	reg  [2:0] state_nxt;
	reg  [3:0] bit_cnt_nxt;
	reg  [7:0] shift_nxt;
	reg        ack_phase_nxt;
	reg        sda_oe_nxt;
	reg  [7:0] sub_nxt;
	reg        buf_mode_nxt;
	reg  [7:0] dir_data_nxt;
	reg        dir_pend_nxt;
	reg  [7:0] hold_nxt;
	reg  [6:0] hold_idx_nxt;
	reg        buffer_locked_nxt;
	reg        armed_nxt;

	// Receiver states
	localparam [2:0] ST_IDLE   = 3'h0;
	localparam [2:0] ST_ADDR   = 3'h1;
	localparam [2:0] ST_SUB    = 3'h2;
	localparam [2:0] ST_DATA   = 3'h3;
	localparam [2:0] ST_IGNORE = 3'h4;

	// Level went from low to high between two samples
	function rise_of;
		input now_lvl;
		input prev_lvl;
		begin
			rise_of = now_lvl & ~prev_lvl;
		end
	endfunction

	// Bus pins and outside levels are sampled twice before use
	pin_sync #(
		.W (5)
	) i_pin_sync (
		.ref_clk  (ref_clk),
		.reset    (reset),
		.async_in ({supply_ok, standby_state, vertical_blank_pulse, sda_in, scl_in}),
		.sync_out (sync_w)
	);

	assign scl_s  = sync_w[0];
	assign sda_s  = sync_w[1];
	assign vbl_s  = sync_w[2];
	assign stby_s = sync_w[3];
	assign pwr_s  = sync_w[4];

	// Open-drain: only ever pulls low
	assign sda_out = 1'b0;

	// At 200 MHz a 400 kHz bus gives hundreds of samples per bit
	assign scl_rise   = rise_of(scl_s, scl_d_r);
	// A fall is a rise seen with the samples swapped
	assign scl_fall   = rise_of(scl_d_r, scl_s);
	assign start_cond = scl_s & scl_d_r & sda_d_r & ~sda_s;
	assign stop_cond  = scl_s & scl_d_r & ~sda_d_r & sda_s;
	assign vbl_rise   = rise_of(vbl_s, vbl_d_r);
	assign frame_end  = start_cond | stop_cond;
	assign receiving  = (state_r == ST_ADDR) | (state_r == ST_SUB) | (state_r == ST_DATA);

	// Supply low or buffer occupied blocks every acknowledge
	assign may_ack = pwr_s & ~buffer_locked;

	always @(posedge ref_clk) begin
		if (reset) begin
			// Match the cleared synchroniser so no false edge follows reset
			scl_d_r <= 1'b0;
			sda_d_r <= 1'b0;
			vbl_d_r <= 1'b0;
		end else begin
			scl_d_r <= scl_s;
			sda_d_r <= sda_s;
			vbl_d_r <= vbl_s;
		end
	end

	// Receiver: next state
	always @* begin
		state_nxt         = state_r;
		bit_cnt_nxt       = bit_cnt_r;
		shift_nxt         = shift_r;
		ack_phase_nxt     = ack_phase_r;
		sda_oe_nxt        = sda_oe;
		sub_nxt           = sub_r;
		buf_mode_nxt      = buf_mode_r;
		dir_data_nxt      = dir_data_r;
		dir_pend_nxt      = dir_pend_r;
		hold_nxt          = hold_r;
		hold_idx_nxt      = hold_idx_r;
		buffer_locked_nxt = buffer_locked;
		if (frame_end) begin
			state_nxt     = start_cond ? ST_ADDR : ST_IDLE;
			bit_cnt_nxt   = `BIT_CNT_CLR;
			ack_phase_nxt = 1'b0;
			sda_oe_nxt    = 1'b0;
			dir_pend_nxt  = 1'b0;
		end else if (scl_rise && !ack_phase_r && bit_cnt_r != `BYTE_BITS && receiving) begin
			shift_nxt   = {shift_r[6:0], sda_s};
			bit_cnt_nxt = bit_cnt_r + `BIT_CNT_STEP;
		end else if (scl_fall && ack_phase_r) begin
			// Release while the clock is low, never while it is high
			ack_phase_nxt = 1'b0;
			sda_oe_nxt    = 1'b0;
			bit_cnt_nxt   = `BIT_CNT_CLR;
		end else if (scl_fall && bit_cnt_r == `BYTE_BITS) begin
			case (state_r)
				ST_ADDR: begin
					if (shift_r == `DEV_BUS_ADDRESS && may_ack) begin
						state_nxt     = ST_SUB;
						ack_phase_nxt = 1'b1;
						sda_oe_nxt    = 1'b1;
					end else begin
						state_nxt = ST_IGNORE;
					end
				end
				ST_SUB: begin
					sub_nxt = shift_r;
					// Standby turns a buffered subaddress into a direct one
					buf_mode_nxt = shift_r[`SUB_MODE_BIT] & ~stby_s;
					if (may_ack) begin
						state_nxt     = ST_DATA;
						ack_phase_nxt = 1'b1;
						sda_oe_nxt    = 1'b1;
					end else begin
						state_nxt = ST_IGNORE;
					end
				end
				ST_DATA: begin
					// Subaddress is never advanced for later bytes
					if (!may_ack) begin
						state_nxt = ST_IGNORE;
					end else if (buf_mode_r) begin
						hold_nxt          = shift_r;
						hold_idx_nxt      = sub_r[6:0];
						buffer_locked_nxt = 1'b1;
						ack_phase_nxt     = 1'b1;
						sda_oe_nxt        = 1'b1;
					end else begin
						// Later bytes overwrite, so the last one of the frame lands
						dir_data_nxt  = shift_r;
						dir_pend_nxt  = 1'b1;
						ack_phase_nxt = 1'b1;
						sda_oe_nxt    = 1'b1;
					end
				end
				default: begin
					state_nxt = ST_IGNORE;
				end
			endcase
		end
		// The transfer at blanking frees the buffer for the next write
		if (buf_we)
			buffer_locked_nxt = 1'b0;
	end

	// Receiver: registers
	always @(posedge ref_clk) begin
		if (reset) begin
			state_r       <= ST_IDLE;
			bit_cnt_r     <= `BIT_CNT_CLR;
			shift_r       <= `BYTE_CLR;
			ack_phase_r   <= 1'b0;
			sda_oe        <= 1'b0;
			sub_r         <= `BYTE_CLR;
			buf_mode_r    <= 1'b0;
			dir_data_r    <= `BYTE_CLR;
			dir_pend_r    <= 1'b0;
			hold_r        <= `BYTE_CLR;
			hold_idx_r    <= `IDX_CLR;
			buffer_locked <= 1'b0;
			armed_r       <= 1'b0;
		end else begin
			state_r       <= state_nxt;
			bit_cnt_r     <= bit_cnt_nxt;
			shift_r       <= shift_nxt;
			ack_phase_r   <= ack_phase_nxt;
			sda_oe        <= sda_oe_nxt;
			sub_r         <= sub_nxt;
			buf_mode_r    <= buf_mode_nxt;
			dir_data_r    <= dir_data_nxt;
			dir_pend_r    <= dir_pend_nxt;
			hold_r        <= hold_nxt;
			hold_idx_r    <= hold_idx_nxt;
			buffer_locked <= buffer_locked_nxt;
			armed_r       <= armed_nxt;
		end
	end

	// A STOP meeting a blanking pulse only arms; the transfer waits for the next pulse
	always @* begin
		armed_nxt = armed_r;
		if (buf_we)
			armed_nxt = 1'b0;
		else if (frame_end && buffer_locked)
			armed_nxt = 1'b1;
	end

	// Direct data lands on the STOP or repeated START that closes the frame
	always @* begin
		dir_we = frame_end & dir_pend_r;
		buf_we = vbl_rise & armed_r;
	end

	defl_reg_bank i_defl_reg_bank (
		.ref_clk              (ref_clk),
		.buf_we               (buf_we),
		.buf_index            (hold_idx_r),
		.buf_data             (hold_r),
		.dir_we               (dir_we),
		.dir_index            (sub_r[6:0]),
		.dir_data             (dir_data_r),
		.rd_index             (rd_index),
		.rd_data              (rd_data),
		.full_amplitude       (full_amplitude),
		.position_offset      (position_offset),
		.s_correction_eff     (s_correction_eff),
		.balance_offset       (balance_offset),
		.parallelogram_offset (parallelogram_offset),
		.pin_unbalance_offset (pin_unbalance_offset),
		.soft_start_release   (soft_start_release)
	);

endmodule // deflection_ctrl_i2c_update_port

`default_nettype wire

/* File: tb/defl_port_chk_assertions.sv */
// Checker for the serial update port
`timescale 1ns/10ps
`default_nettype none
module defl_port_chk (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Pins and device state
	input wire logic scl_in,
	input wire logic sda_oe,
	input wire logic vertical_blank_pulse,
	input wire logic standby_state,
	input wire logic supply_ok,
	input wire logic buffer_locked
);
	logic [3:0] since_vbl_r;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	// Saturates so that a long wait reads as stale blanking
	always @(posedge ref_clk)
		if (reset || vertical_blank_pulse)
			since_vbl_r <= 4'h0;
		else if (since_vbl_r != 4'hf)
			since_vbl_r <= since_vbl_r + 4'h1;
	property p_ack_supply; !supply_ok [*8] |-> !$rose(sda_oe); endproperty
	a_ack_supply: assert property (p_ack_supply) else $error("ack with low supply");
	property p_ack_scl_low; $rose(sda_oe) |-> !scl_in; endproperty
	a_ack_scl_low: assert property (p_ack_scl_low) else $error("ack while clock high");
	property p_oe_still; scl_in [*6] |-> $stable(sda_oe); endproperty
	a_oe_still: assert property (p_oe_still) else $error("data moved, clock high");
	property p_oe_release; sda_oe && $fell(scl_in) |-> ##[1:6] !sda_oe; endproperty
	a_oe_release: assert property (p_oe_release) else $error("ack held too long");
	property p_lock_fall; $fell(buffer_locked) |-> since_vbl_r < 4'h8; endproperty
	a_lock_fall: assert property (p_lock_fall) else $error("unlock without blank");
	property p_lock_hold; buffer_locked && since_vbl_r == 4'hf |=> buffer_locked; endproperty
	a_lock_hold: assert property (p_lock_hold) else $error("lock lost early");
	property p_lock_no_ack; buffer_locked && $past(buffer_locked) |-> !$rose(sda_oe); endproperty
	a_lock_no_ack: assert property (p_lock_no_ack) else $error("ack while locked");
	property p_standby; standby_state [*8] |-> !$rose(buffer_locked); endproperty
	a_standby: assert property (p_standby) else $error("lock in standby");
endmodule // defl_port_chk
bind deflection_ctrl_i2c_update_port defl_port_chk i_defl_port_chk (.ref_clk(ref_clk),
	.reset(reset), .scl_in(scl_in), .sda_oe(sda_oe), .vertical_blank_pulse(vertical_blank_pulse),
	.standby_state(standby_state), .supply_ok(supply_ok), .buffer_locked(buffer_locked));
`default_nettype wire

/* File: tb/i2c_host.sv */
// Bus master model of the host controller
`timescale 1ns/10ps
`default_nettype none
module i2c_host (
	// Clock
	input  wire logic ref_clk,
	// Bus pins, data is open drain
	output logic      scl,
	output logic      sda_m,
	input  wire logic sda_line,
	// Acknowledge report
	output logic      ack_v,
	output logic      ack_got
);
	localparam int H = 8; // Half of an 80 ns bus clock
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
		ack_v = 1'b0;
		ack_got = 1'b0;
	end
	task automatic hw(input int n); repeat (n) @(posedge ref_clk); endtask
	// Data moves two cycles after the clock falls, so hold never hinges on sync order
	task automatic bitx(input logic b);
		hw(2);
		sda_m <= b;
		hw(H - 2);
		scl <= 1'b1;
		hw(H);
		scl <= 1'b0;
	endtask
	task automatic byte_tx(input logic [7:0] v, output logic a);
		for (int i = 7; i >= 0; i--) bitx(v[i]);
		hw(2);
		sda_m <= 1'b1;
		hw(H - 2);
		scl <= 1'b1;
		hw(H - 1);
		a = !sda_line;
		ack_got <= !sda_line;
		ack_v <= 1'b1;
		hw(1);
		ack_v <= 1'b0;
		scl <= 1'b0;
	endtask
	// Stops at the first refusal, as a real master would
	task automatic frame(input logic [7:0] a, s, d0, d1, input int n);
		logic k;
		hw(2);
		sda_m <= 1'b1;
		hw(H);
		scl <= 1'b1;
		hw(H);
		sda_m <= 1'b0;
		hw(H);
		scl <= 1'b0;
		byte_tx(a, k);
		if (k) byte_tx(s, k);
		if (k) byte_tx(d0, k);
		if (k && n > 1) byte_tx(d1, k);
		hw(2);
		sda_m <= 1'b0;
		hw(H);
		scl <= 1'b1;
		hw(H);
		sda_m <= 1'b1;
		hw(H);
	endtask
endmodule // i2c_host
`default_nettype wire

/* File: tb/deflection_ctrl_i2c_update_port_tb.sv */
// Self-checking bench for the serial update port
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
	$display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module deflection_ctrl_i2c_update_port_tb;
	logic       ref_clk = 1'b0;
	logic       reset = 1'b1;
	logic       vertical_blank_pulse = 1'b0;
	logic       standby_state = 1'b0;
	logic       supply_ok = 1'b1;
	logic       chk_v = 1'b0;
	logic [6:0] rd_index = 7'h00;
	logic [7:0] rd_data, pos_off, bal_off, s_eff, pin_off, par_off, chk_d, r, g, e;
	logic       full_amp, sda_out, sda_oe, scl, sda_m, ack_v, ack_got, locked, soft_st;
	wire        sda_line = sda_m & ~(sda_oe & ~sda_out);
	logic [7:0] exp_q[$];
	int         n_fail = 0;
	int         comparisons = 0;
	int         cyc = 0;
	deflection_ctrl_i2c_update_port i_deflection_ctrl_i2c_update_port (.ref_clk(ref_clk),
		.reset(reset), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
		.vertical_blank_pulse(vertical_blank_pulse), .standby_state(standby_state),
		.supply_ok(supply_ok), .buffer_locked(locked), .rd_index(rd_index), .rd_data(rd_data),
		.full_amplitude(full_amp), .position_offset(pos_off), .s_correction_eff(s_eff),
		.balance_offset(bal_off), .parallelogram_offset(par_off),
		.pin_unbalance_offset(pin_off), .soft_start_release(soft_st));
	i2c_host i_i2c_host (.ref_clk(ref_clk), .scl(scl), .sda_m(sda_m), .sda_line(sda_line),
		.ack_v(ack_v), .ack_got(ack_got));
	initial forever #2.5 ref_clk = ~ref_clk;
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (ack_v || chk_v) begin
			g = ack_v ? {7'h0, ack_got} : chk_d;
			e = exp_q.pop_front();
			`CHK(g, e)
		end
		if (cyc == 40000) begin
			n_fail++;
			tally_and_finish();
		end
	end
	task automatic hw(input int n); repeat (n) @(posedge ref_clk); endtask
	task automatic note(input logic [7:0] v); exp_q.push_back(v); endtask
	task automatic put(input logic [7:0] v);
		chk_d <= v;
		chk_v <= 1'b1;
		hw(1);
		chk_v <= 1'b0;
		hw(1);
	endtask
	task automatic rd(input logic [6:0] i, input logic [7:0] v);
		note(v);
		rd_index <= i;
		hw(3);
		put(rd_data);
	endtask
	// k acknowledges expected, then one refusal if the frame is cut short
	task automatic go(input logic [7:0] a, s, d0, d1, input int n, k);
		for (int i = 0; i < k; i++) note(8'h01);
		if (k < n + 2) note(8'h00);
		i_i2c_host.frame(a, s, d0, d1, n);
		hw(4);
	endtask
	initial begin
		void'($urandom(32'h62b6e7bc));
		hw(20);
		reset <= 1'b0;
		hw(6);
		r = 8'($urandom);
		go(8'h8c, 8'h22, r, r, 1, 3);
		rd(7'h22, r);
		note(r - 8'h40);
		put(pos_off);
		$display("direct done");
		go(8'h8d, 8'h22, ~r, r, 1, 0);
		go(8'h0c, 8'h22, ~r, r, 1, 0);
		supply_ok <= 1'b0;
		hw(4);
		go(8'h8c, 8'h22, ~r, r, 1, 0);
		supply_ok <= 1'b1;
		rd(7'h22, r);
		$display("refusal done");
		r = 8'($urandom);
		go(8'h8c, 8'h24, ~r, r, 2, 4);
		rd(7'h24, r);
		note(r - 8'h08);
		put(bal_off);
		r = 8'($urandom);
		go(8'h8c, 8'h25, r, 8'h00, 1, 3);
		note(r - 8'h20);
		put(par_off);
		$display("multi byte done");
		// Preset directly, then tweak one value in step with blanking
		go(8'h8c, 8'h20, 8'h10, 8'h00, 1, 3);
		go(8'h8c, 8'ha0, 8'h7f, 8'h00, 2, 3);
		note(8'h01);
		put({7'h0, locked});
		rd(7'h20, 8'h10);
		go(8'h8c, 8'h21, 8'h3f, 8'h00, 1, 0);
		vertical_blank_pulse <= 1'b1;
		hw(6);
		vertical_blank_pulse <= 1'b0;
		hw(10);
		note(8'h00);
		put({7'h0, locked});
		rd(7'h20, 8'h7f);
		go(8'h8c, 8'h21, 8'h3f, 8'h00, 1, 3);
		go(8'h8c, 8'h0f, 8'h00, 8'h00, 1, 3);
		note(8'h01);
		put({7'h0, full_amp});
		$display("buffered done");
		standby_state <= 1'b1;
		hw(4);
		go(8'h8c, 8'ha6, 8'h20, 8'h00, 1, 3);
		rd(7'h26, 8'h20);
		note(8'h00);
		put(pin_off);
		standby_state <= 1'b0;
		go(8'h8c, 8'h23, 8'h55, 8'h00, 1, 3);
		go(8'h8c, 8'h02, 8'h40, 8'h00, 1, 3);
		note(8'h00);
		put(s_eff);
		go(8'h8c, 8'h1a, 8'h02, 8'h00, 1, 3);
		note(8'h01);
		put({7'h0, soft_st});
		$display("standby and centring done");
		tally_and_finish();
	end
endmodule // deflection_ctrl_i2c_update_port_tb
`default_nettype wire
